// file: src/sfe_core.sv
// Purpose: erase and power-mode instruction sequencer of a serial flash
// Assumes: link clock far slower than ref_clk; protection map on a port
// Notes: memory array is outside; erase request carries range and fill
`timescale 1ns/1ps
module sfe_core
    import sfe_pkg::*;
#(
    parameter int LOCKOUT_CYCLES = sfe_pkg::LOCKOUT_CYC,
    parameter int PAGE_CYCLES    = sfe_pkg::PAGE_CLEAR_CYC,
    parameter int SECTOR_CYCLES  = sfe_pkg::SECTOR_CLEAR_CYC,
    parameter int ENTRY_CYCLES   = sfe_pkg::SLEEP_ENTRY_CYC,
    parameter int EXIT_CYCLES    = sfe_pkg::SLEEP_EXIT_CYC
) (
    input  wire logic                         ref_clk,
    input  wire logic                         nrst,
    input  wire logic                         sel_n,
    input  wire logic                         sclk,
    input  wire logic                         sdi,
    input  wire logic                         ext_busy,
    input  wire logic                         prot_hit,
    output logic [sfe_pkg::USED_ADDR_W-1:0]   check_addr,
    output logic                              check_sector,
    output logic                              clear_start,
    output logic [sfe_pkg::USED_ADDR_W-1:0]   clear_base,
    output logic [sfe_pkg::USED_ADDR_W-1:0]   clear_len,
    output logic [7:0]                        clear_fill,
    output logic                              busy_flag,
    output logic                              write_unlock_latch,
    output logic                              asleep,
    output logic                              standby,
    output logic                              lockout
);
    import sfe_pkg::*;

    logic [2:0] pins_s;
    logic       sel_s, sclk_s, sdi_s;

    // pins pass two flops before any logic looks at them
    sfe_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .async_in ({sel_n, sclk, sdi}),
        .sync_out (pins_s)
    );
    assign {sel_s, sclk_s, sdi_s} = pins_s;

    typedef struct packed {
        logic                   sel_q;
        logic                   sclk_q;
        logic [5:0]             nbits_q;
        logic                   over_q;
        logic [7:0]             op_q;
        logic [ADDR_W-1:0]      addr_q;
        sfe_mode_t              mode_q;
        logic [TIMER_W-1:0]     timer_q;
        logic [TIMER_W-1:0]     lock_q;
        logic                   wul_q;
        logic                   sector_q;
        logic                   start_q;
        logic [USED_ADDR_W-1:0] base_q;
        logic [USED_ADDR_W-1:0] len_q;
        logic [7:0]             fill_q;
    } sfe_state_t;

    sfe_state_t s_q, s_d;

    logic sclk_rise, sel_rise, sel_fall;
    logic is_erase, erase_ok, sleep_ok, wake_ok;
    logic run_busy, lock_on;
    logic [USED_ADDR_W-1:0] tgt;

    assign sclk_rise = sclk_s & ~s_q.sclk_q & ~sel_s;
    assign sel_rise  = sel_s & ~s_q.sel_q;
    assign sel_fall  = ~sel_s & s_q.sel_q;
    assign run_busy  = (s_q.mode_q == SFE_ERASING) | ext_busy;
    assign lock_on   = (s_q.lock_q != '0);
    // top three address bits dropped here
    assign tgt       = s_q.addr_q[USED_ADDR_W-1:0];
    assign is_erase  = (s_q.op_q == OP_PAGE_CLEAR)
                     | (s_q.op_q == OP_SECTOR_CLEAR);
    assign check_addr   = tgt;
    assign check_sector = (s_q.op_q == OP_SECTOR_CLEAR);

    // acceptance terms evaluated at the select rising edge
    assign erase_ok = is_erase & (s_q.nbits_q == 6'(ERASE_BITS))
                    & ~s_q.over_q
                    & s_q.wul_q
                    & ~prot_hit
                    & ~run_busy
                    & ~lock_on
                    & (s_q.mode_q == SFE_STANDBY);
    assign sleep_ok = (s_q.op_q == OP_SLEEP_ENTRY)
                    & (s_q.nbits_q == 6'(CMD_BITS)) & ~s_q.over_q
                    & ~run_busy
                    & (s_q.mode_q == SFE_STANDBY);
    assign wake_ok  = (s_q.op_q == OP_SLEEP_RELEASE)
                    & (s_q.nbits_q == 6'(CMD_BITS)) & ~s_q.over_q
                    & ~run_busy
                    & (s_q.mode_q == SFE_ASLEEP);

    // whole next state in one place
    always_comb begin
        s_d         = s_q;
        s_d.sel_q   = sel_s;
        s_d.sclk_q  = sclk_s;
        s_d.start_q = 1'b0;
        if (lock_on) begin
            s_d.lock_q = s_q.lock_q - 1'b1;
        end
        if (sel_fall) begin
            s_d.nbits_q = '0;
            s_d.over_q  = 1'b0;
        end
        // shift in one bit per rising serial clock while selected
        if (sclk_rise) begin
            if (s_q.nbits_q < 6'(CMD_BITS)) begin
                s_d.op_q = {s_q.op_q[6:0], sdi_s};
            end else if (s_q.nbits_q < 6'(ERASE_BITS)) begin
                s_d.addr_q = {s_q.addr_q[ADDR_W-2:0], sdi_s};
            end
            if (s_q.nbits_q == 6'(ERASE_BITS)) begin
                s_d.over_q = 1'b1;   // saturate, mark too long
            end else begin
                s_d.nbits_q = s_q.nbits_q + 6'h01;
            end
            // write unlock decoded at the eighth bit; asleep ignores it
            if (s_q.nbits_q == 6'(CMD_BITS - 1)
                && {s_q.op_q[6:0], sdi_s} == OP_WRITE_UNLOCK
                && s_q.mode_q == SFE_STANDBY && !lock_on
                && !run_busy) begin
                s_d.wul_q = 1'b1;
            end
            if (s_q.nbits_q == 6'(CMD_BITS - 1)
                && {s_q.op_q[6:0], sdi_s} == OP_WRITE_LOCK
                && s_q.mode_q == SFE_STANDBY && !run_busy) begin
                s_d.wul_q = 1'b0;
            end
        end
        // mode sequencer
        unique case (s_q.mode_q)
            SFE_STANDBY: begin
                if (sel_rise && erase_ok) begin
                    s_d.mode_q   = SFE_ERASING;
                    s_d.sector_q = check_sector;
                    s_d.start_q  = 1'b1;
                    s_d.fill_q   = ERASED_BYTE;
                    if (check_sector) begin
                        s_d.base_q  = {tgt[USED_ADDR_W-1:SECTOR_LSB],
                                       {SECTOR_LSB{1'b0}}};
                        s_d.len_q   = USED_ADDR_W'(1 << SECTOR_LSB);
                        s_d.timer_q = TIMER_W'(SECTOR_CYCLES);
                    end else begin
                        s_d.base_q  = {tgt[USED_ADDR_W-1:PAGE_LSB],
                                       {PAGE_LSB{1'b0}}};
                        s_d.len_q   = USED_ADDR_W'(1 << PAGE_LSB);
                        s_d.timer_q = TIMER_W'(PAGE_CYCLES);
                    end
                end else if (sel_rise && sleep_ok) begin
                    s_d.mode_q  = SFE_ENTERING;
                    s_d.timer_q = TIMER_W'(ENTRY_CYCLES);
                end
            end
            SFE_ERASING: begin
                // latch dropped halfway through the cycle
                if (s_q.timer_q <= (s_q.sector_q
                                    ? TIMER_W'(SECTOR_CYCLES / 2)
                                    : TIMER_W'(PAGE_CYCLES / 2))
                    || s_q.timer_q <= 24'h000002) begin
                    s_d.wul_q = 1'b0;
                end
                if (s_q.timer_q <= 24'h000001) begin
                    s_d.mode_q = SFE_STANDBY;
                    s_d.wul_q  = 1'b0;
                end else begin
                    s_d.timer_q = s_q.timer_q - 1'b1;
                end
            end
            SFE_ENTERING: begin
                if (s_q.timer_q <= 24'h000001) begin
                    s_d.mode_q = SFE_ASLEEP;
                end else begin
                    s_d.timer_q = s_q.timer_q - 1'b1;
                end
            end
            SFE_ASLEEP: begin
                if (sel_rise && wake_ok) begin
                    s_d.mode_q  = SFE_WAKING;
                    s_d.timer_q = TIMER_W'(EXIT_CYCLES);
                end
            end
            SFE_WAKING: begin
                // host keeps select high meanwhile
                if (s_q.timer_q <= 24'h000001) begin
                    s_d.mode_q = SFE_STANDBY;
                end else begin
                    s_d.timer_q = s_q.timer_q - 1'b1;
                end
            end
            default: begin
                s_d.mode_q = SFE_STANDBY;
            end
        endcase
    end

    // power-on reset: standby, flags clear, lockout armed
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_q         <= '0;
            s_q.sel_q   <= 1'b1;
            s_q.sclk_q  <= 1'b1;
            s_q.mode_q  <= SFE_STANDBY;
            s_q.lock_q  <= TIMER_W'(LOCKOUT_CYCLES);
            s_q.fill_q  <= ERASED_BYTE;
        end else begin
            s_q <= s_d;
        end
    end

    // flags and erase request are straight from the state flops, except standby, which is also gated by ext_busy
    assign busy_flag          = (s_q.mode_q == SFE_ERASING);
    assign write_unlock_latch = s_q.wul_q;
    assign asleep             = (s_q.mode_q == SFE_ASLEEP);
    assign standby            = (s_q.mode_q == SFE_STANDBY)
                              & s_q.sel_q & ~ext_busy;
    assign lockout            = lock_on;
    assign clear_start        = s_q.start_q;
    assign clear_base         = s_q.base_q;
    assign clear_len          = s_q.len_q;
    assign clear_fill         = s_q.fill_q;

    // an accepted erase starts the cycle on the next edge
    property p_erase_start;
        @(posedge ref_clk) disable iff (!nrst)
        (s_q.mode_q == SFE_STANDBY && sel_rise && erase_ok)
            |=> (busy_flag && clear_start);
    endproperty
    a_erase_start: assert property (p_erase_start)
        else $error("accepted erase did not start");

    property p_needs_latch;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(busy_flag) |-> $past(s_q.wul_q);
    endproperty
    a_needs_latch: assert property (p_needs_latch)
        else $error("erase started without unlock latch");

    property p_latch_clear;
        @(posedge ref_clk) disable iff (!nrst)
        $fell(busy_flag) |-> !write_unlock_latch;
    endproperty
    a_latch_clear: assert property (p_latch_clear)
        else $error("unlock latch survived erase cycle");

    property p_protected;
        @(posedge ref_clk) disable iff (!nrst)
        (sel_rise && prot_hit && s_q.mode_q == SFE_STANDBY)
            |=> !clear_start;
    endproperty
    a_protected: assert property (p_protected)
        else $error("protected range erased");

    property p_bit_count;
        @(posedge ref_clk) disable iff (!nrst)
        clear_start |-> $past(s_q.nbits_q) == 6'(ERASE_BITS)
                        && !$past(s_q.over_q);
    endproperty
    a_bit_count: assert property (p_bit_count)
        else $error("erase taken with wrong bit count");

    property p_fill;
        @(posedge ref_clk) disable iff (!nrst)
        clear_start |-> clear_fill == ERASED_BYTE
                        && clear_base[PAGE_LSB-1:0] == '0;
    endproperty
    a_fill: assert property (p_fill)
        else $error("erase fill or base wrong");

    property p_asleep_quiet;
        @(posedge ref_clk) disable iff (!nrst)
        asleep |=> !clear_start && !$rose(write_unlock_latch);
    endproperty
    a_asleep_quiet: assert property (p_asleep_quiet)
        else $error("instruction acted while asleep");

    property p_lockout;
        @(posedge ref_clk) disable iff (!nrst)
        lockout |=> !$rose(write_unlock_latch) && !clear_start;
    endproperty
    a_lockout: assert property (p_lockout)
        else $error("write accepted during lockout");

    property p_busy_reject;
        @(posedge ref_clk) disable iff (!nrst)
        (busy_flag && !$fell(busy_flag)) |=> !asleep && !clear_start;
    endproperty
    a_busy_reject: assert property (p_busy_reject)
        else $error("instruction disturbed running cycle");

    property p_sleep_delay;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(s_q.mode_q == SFE_ENTERING) |-> !asleep [*2];
    endproperty
    a_sleep_delay: assert property (p_sleep_delay)
        else $error("sleep entered without delay");

    // erase ranges are whole aligned pages or sectors
    property p_sector_range;
        @(posedge ref_clk) disable iff (!nrst)
        (clear_start && s_q.sector_q)
            |-> clear_base[SECTOR_LSB-1:0] == '0
                && clear_len == USED_ADDR_W'(1 << SECTOR_LSB);
    endproperty
    a_sector_range: assert property (p_sector_range)
        else $error("sector erase range wrong");

    property p_page_range;
        @(posedge ref_clk) disable iff (!nrst)
        (clear_start && !s_q.sector_q)
            |-> clear_len == USED_ADDR_W'(1 << PAGE_LSB);
    endproperty
    a_page_range: assert property (p_page_range)
        else $error("page erase length wrong");

    // sleep and release frames are exactly one opcode long
    property p_sleep_bits;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(s_q.mode_q == SFE_ENTERING)
            |-> $past(s_q.nbits_q) == 6'(CMD_BITS) && !$past(s_q.over_q);
    endproperty
    a_sleep_bits: assert property (p_sleep_bits)
        else $error("sleep taken with wrong bit count");

    property p_wake_bits;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(s_q.mode_q == SFE_WAKING)
            |-> $past(s_q.nbits_q) == 6'(CMD_BITS) && !$past(s_q.over_q);
    endproperty
    a_wake_bits: assert property (p_wake_bits)
        else $error("release taken with wrong bit count");

    // a plain deselect never reaches sleep
    property p_sleep_cmd;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(asleep) |-> $past(s_q.mode_q) == SFE_ENTERING;
    endproperty
    a_sleep_cmd: assert property (p_sleep_cmd)
        else $error("sleep entered without its instruction");

    // latch already gone in the last cycle of an erase
    property p_latch_early;
        @(posedge ref_clk) disable iff (!nrst)
        (busy_flag && s_q.timer_q == 24'h000001) |-> !write_unlock_latch;
    endproperty
    a_latch_early: assert property (p_latch_early)
        else $error("unlock latch still set at erase end");

endmodule : sfe_core

// file: src/sfe_pkg.sv
// Purpose: constants for the serial flash erase and power-mode sequencer
// Assumes: 40 MHz ref_clk, serial link sampled as plain pins
// Notes: opcodes and timing figures are plain defaults
package sfe_pkg;
    localparam logic [7:0] OP_WRITE_UNLOCK  = 8'h06;
    localparam logic [7:0] OP_WRITE_LOCK    = 8'h04;
    localparam logic [7:0] OP_PAGE_CLEAR    = 8'hDB;
    localparam logic [7:0] OP_SECTOR_CLEAR  = 8'hD8;
    localparam logic [7:0] OP_SLEEP_ENTRY   = 8'hB9;
    localparam logic [7:0] OP_SLEEP_RELEASE = 8'hAB;
    localparam int         ADDR_W           = 24;
    localparam int         USED_ADDR_W      = 21;
    localparam int         PAGE_LSB         = 8;
    localparam int         SECTOR_LSB       = 16;
    localparam int         CMD_BITS         = 8;
    localparam int         ERASE_BITS       = 32;
    localparam logic [7:0] ERASED_BYTE      = 8'hFF;
    localparam int         CLK_HZ           = 40_000_000;
    localparam int         LOCKOUT_US       = 1000;
    localparam int         LOCKOUT_CYC      = LOCKOUT_US * (CLK_HZ / 1_000_000);
    localparam int         PAGE_CLEAR_US    = 10;
    localparam int         SECTOR_CLEAR_US  = 50;
    localparam int         SLEEP_ENTRY_US   = 3;
    localparam int         SLEEP_EXIT_US    = 30;
    localparam int         PAGE_CLEAR_CYC   = PAGE_CLEAR_US * 40;
    localparam int         SECTOR_CLEAR_CYC = SECTOR_CLEAR_US * 40;
    localparam int         SLEEP_ENTRY_CYC  = SLEEP_ENTRY_US * 40;
    localparam int         SLEEP_EXIT_CYC   = SLEEP_EXIT_US * 40;
    localparam int         TIMER_W          = 24;
    typedef enum logic [2:0] {
        SFE_STANDBY  = 3'b000,
        SFE_ERASING  = 3'b001,
        SFE_ENTERING = 3'b010,
        SFE_ASLEEP   = 3'b011,
        SFE_WAKING   = 3'b100
    } sfe_mode_t;
endpackage : sfe_pkg

// file: src/sfe_sync.sv
// Purpose: two-flop synchroniser for the serial link pins
// Assumes: inputs asynchronous to ref_clk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module sfe_sync #(
    parameter int           W       = 3,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    // two stages; reset values come from constants at instance
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : sfe_sync

// file: verif/sfe_host.sv
// Purpose: host serial master model driving select, clock and data
// Assumes: 200 ns link clock, mode 0, clock idles low between frames
// Notes: frame bits sent msb first from the top of a 32-bit word
`timescale 1ns/1ps
module sfe_host (
    input  wire logic ref_clk,
    output logic      sel_n,
    output logic      sclk,
    output logic      sdi
);
    logic active;
    logic data_bit;
    logic idle_bit;

    initial begin
        sel_n    = 1'b1;
        sclk     = 1'b0;
        data_bit = 1'b0;
        idle_bit = 1'b0;
        active   = 1'b0;
    end

    // released data line keeps changing so a stale bit never looks valid
    always @(negedge ref_clk) begin
        idle_bit <= ~idle_bit;
    end

    // one driver for the pin; no race with the frame's first bit
    assign sdi = active ? data_bit : idle_bit;

    // one framed transfer; bits past 32 wrap, used only to overrun a count
    task automatic send(input logic [31:0] frame, input int nbits);
        @(negedge ref_clk);
        active = 1'b1;
        sel_n  = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            data_bit = frame[(31 - i) & 31];
            #100;
            sclk = 1'b1;
            #100;
            sclk = 1'b0;
        end
        #100;
        sel_n = 1'b1;
        #600;
        active = 1'b0;
    endtask : send
endmodule : sfe_host

// file: verif/sfe_core_tb.sv
// Purpose: self-checking bench for the erase and power-mode sequencer
// Assumes: bottom sector protected; short timing parameters
// Notes: table rows cover erase decoding, odd cases follow by hand
`timescale 1ns/1ps
module sfe_core_tb;
    import sfe_pkg::*;
    localparam int LOCK_C = 2000;
    localparam int SEL_WAIT_C = 1200; // 30 us of ref_clk
    localparam int PAGE_C = 100;
    localparam int SECT_C = 150;
    localparam int ENTRY_C = 20;
    localparam int EXIT_C = 20;
    typedef struct {
        logic [31:0] frame;
        int          nbits;
        bit          unlock;
        bit          go;
        logic [20:0] base;
        logic [20:0] len;
    } sfe_row_t;
    logic                   ref_clk, nrst, ext_busy, prot_hit;
    logic                   sel_n, sclk, sdi, clear_start, busy_flag;
    logic                   write_unlock_latch, asleep, standby, lockout;
    logic                   check_sector;
    logic [USED_ADDR_W-1:0] check_addr, clear_base, clear_len;
    logic [USED_ADDR_W-1:0] seen_base, seen_len;
    logic [7:0]             clear_fill, seen_fill;
    int                     bad_count, check_count, starts, busy_len, n;
    sfe_row_t               rows [8];

    // bottom sector stands for the protected area
    assign prot_hit = (check_addr[20:16] == 5'h00);

    sfe_core #(.LOCKOUT_CYCLES(LOCK_C), .PAGE_CYCLES(PAGE_C),
        .SECTOR_CYCLES(SECT_C), .ENTRY_CYCLES(ENTRY_C),
        .EXIT_CYCLES(EXIT_C)) u_dut (
        .ref_clk(ref_clk), .nrst(nrst), .sel_n(sel_n), .sclk(sclk),
        .sdi(sdi), .ext_busy(ext_busy), .prot_hit(prot_hit),
        .check_addr(check_addr), .check_sector(check_sector),
        .clear_start(clear_start),
        .clear_base(clear_base), .clear_len(clear_len),
        .clear_fill(clear_fill), .busy_flag(busy_flag),
        .write_unlock_latch(write_unlock_latch), .asleep(asleep),
        .standby(standby), .lockout(lockout));

    sfe_host u_host (.ref_clk(ref_clk), .sel_n(sel_n), .sclk(sclk),
        .sdi(sdi));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // start pulses are one cycle wide, so capture them as they happen
    always @(posedge ref_clk) begin
        if (clear_start === 1'b1) begin
            starts    <= starts + 1;
            seen_base <= clear_base;
            seen_len  <= clear_len;
            seen_fill <= clear_fill;
            busy_len  <= 0;
        end else if (busy_flag === 1'b1) begin
            busy_len <= busy_len + 1;
        end
    end

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(negedge ref_clk);
    endtask : cyc

    task automatic unlock();
        u_host.send({OP_WRITE_UNLOCK, 24'h000000}, CMD_BITS);
    endtask : unlock

    // bounded wait for the erase cycle to end
    task automatic wait_idle();
        int i;
        i = 0;
        while (busy_flag !== 1'b0 && i < 500) begin
            @(negedge ref_clk);
            i++;
        end
        chk("idle", busy_flag, 1'b0);
    endtask : wait_idle

    task automatic report_and_stop();
        if (bad_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    initial begin
        #1ms;
        bad_count++;
        report_and_stop();
    end

    initial begin
        nrst     = 1'b0;
        ext_busy = 1'b0;
        rows[0] = '{{OP_PAGE_CLEAR, 24'hE12345}, 32, 1, 1, 21'h012300, 21'h100};
        rows[1] = '{{OP_SECTOR_CLEAR, 24'h1F5678}, 32, 1, 1, 21'h1F0000,
                    21'h10000};
        rows[2] = '{{OP_PAGE_CLEAR, 24'h034567}, 32, 0, 0, 21'h0, 21'h0};
        rows[3] = '{{OP_PAGE_CLEAR, 24'h034567}, 24, 1, 0, 21'h0, 21'h0};
        rows[4] = '{{OP_PAGE_CLEAR, 24'h034567}, 33, 1, 0, 21'h0, 21'h0};
        rows[5] = '{{OP_PAGE_CLEAR, 24'h001200}, 32, 1, 0, 21'h0, 21'h0};
        rows[6] = '{{OP_SECTOR_CLEAR, 24'h00FFFF}, 32, 1, 0, 21'h0, 21'h0};
        rows[7] = '{{OP_SECTOR_CLEAR, 24'hA20000}, 32, 1, 1, 21'h020000,
                    21'h10000};
        cyc(10);
        chk("rst_busy", busy_flag, 1'b0);
        chk("rst_latch", write_unlock_latch, 1'b0);
        chk("rst_sleep", asleep, 1'b0);
        chk("rst_start", clear_start, 1'b0);
        cyc(10);
        nrst = 1'b1;
        cyc(2);
        chk("up_standby", standby, 1'b1);
        cyc(SEL_WAIT_C);
        unlock();
        chk("lock_latch", write_unlock_latch, 1'b0);
        chk("lock_on", lockout, 1'b1);
        cyc(LOCK_C);
        chk("lock_off", lockout, 1'b0);
        foreach (rows[k]) begin
            n = starts;
            if (rows[k].unlock) unlock();
            u_host.send(rows[k].frame, rows[k].nbits);
            chk("sector", check_sector,
                rows[k].frame[31:24] == OP_SECTOR_CLEAR);
            chk("starts", starts - n, rows[k].go);
            if (rows[k].go) begin
                chk("busy", busy_flag, 1'b1);
                chk("not_standby", standby, 1'b0);
                chk("base", seen_base, rows[k].base);
                chk("len", seen_len, rows[k].len);
                chk("fill", seen_fill, ERASED_BYTE);
                wait_idle();
                n = (rows[k].len == 21'h100) ? PAGE_C : SECT_C;
                chk("busy_len", busy_len >= n - 1 && busy_len <= n + 1,
                    1'b1);
                chk("latch_end", write_unlock_latch, 1'b0);
                chk("standby", standby, 1'b1);
            end
        end
        // outside cycle running: erase and sleep refused
        unlock();
        ext_busy = 1'b1;
        n = starts;
        u_host.send({OP_PAGE_CLEAR, 24'h045600}, ERASE_BITS);
        u_host.send({OP_SLEEP_ENTRY, 24'h0}, CMD_BITS);
        cyc(ENTRY_C + 5);
        chk("ext_start", starts - n, 0);
        chk("ext_sleep", asleep, 1'b0);
        ext_busy = 1'b0;
        // own erase running: sleep refused, cycle untouched
        u_host.send({OP_PAGE_CLEAR, 24'h045600}, ERASE_BITS);
        u_host.send({OP_SLEEP_ENTRY, 24'h0}, CMD_BITS);
        cyc(ENTRY_C + 5);
        chk("busy_sleep", asleep, 1'b0);
        wait_idle();
        chk("busy_runs", busy_len >= PAGE_C - 1, 1'b1);
        // sleep entry needs exactly eight bits
        u_host.send({OP_SLEEP_ENTRY, 24'h0}, CMD_BITS + 1);
        cyc(ENTRY_C + 5);
        chk("sleep_9", asleep, 1'b0);
        u_host.send({OP_SLEEP_ENTRY, 24'h0}, CMD_BITS);
        cyc(ENTRY_C + 5);
        chk("sleep_8", asleep, 1'b1);
        n = starts;
        unlock();
        u_host.send({OP_PAGE_CLEAR, 24'h045600}, ERASE_BITS);
        chk("sleep_erase", starts - n, 0);
        chk("sleep_latch", write_unlock_latch, 1'b0);
        u_host.send({OP_SLEEP_RELEASE, 24'h0}, CMD_BITS + 1);
        chk("release_9", asleep, 1'b1);
        u_host.send({OP_SLEEP_RELEASE, 24'h0}, CMD_BITS);
        chk("release_8", asleep, 1'b0);
        chk("wake_standby", standby, 1'b1);
        // reset in mid erase drops everything
        unlock();
        u_host.send({OP_SECTOR_CLEAR, 24'h050000}, ERASE_BITS);
        chk("pre_rst_busy", busy_flag, 1'b1);
        nrst = 1'b0;
        cyc(2);
        chk("mid_rst_busy", busy_flag, 1'b0);
        chk("mid_rst_latch", write_unlock_latch, 1'b0);
        nrst = 1'b1;
        cyc(2);
        chk("mid_lock", lockout, 1'b1);
        chk("mid_standby", standby, 1'b1);
        report_and_stop();
    end
endmodule : sfe_core_tb
